// ===== cja_exec.sv
/*
  Execution unit for absolute call/jump, add, add-with-carry and logical-AND
  (byte forms and carry AND complemented bit). One instruction per cycle.
  Assumes the fetch logic presents the instruction at program_counter with
  instr_valid, and the port pins arrive asynchronously.
*/
// Notes on behaviour
// - call pushes pc+2 low first, sp pre-incremented
// - call target: pc+2 top five, opcode bits, byte
// - jump takes top five bits of pc+2, loads low eleven
// - carry and aux carry follow bit 7, 3
// - overflow is carry6 xor carry7
// - add puts acc plus source into acc
// - add-with-carry also adds current carry flag
// - add-with-carry takes the same four sources
// - byte logical-AND stores result, flags untouched unless PSW is the direct destination
// - six logical-AND operand combinations supported
// - read-modify of port uses output latch
// - carry becomes carry AND inverted addressed bit
`timescale 1ns/1ps
`default_nettype none
`include "cja_map.svh"

module cja_exec (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire cja_pkg::cja_instr_t instr,
  input wire logic [7:0] port_pin,
  output cja_pkg::cja_core_t core_state,
  output logic [7:0] port_latch,
  output logic instr_done,
  output logic instr_illegal
);
  import cja_pkg::*;

  logic [7:0] ram [0:255];
  logic [15:0] pc_reg, pc_next;
  logic [7:0] sp_reg, sp_next, acc_reg, acc_next, psw_reg, psw_next;
  logic [7:0] latch_reg, latch_next, pin_meta_reg, pin_sync_reg;
  logic done_reg, illegal_reg;

  // direct-space read; latch selects port latch over pins for read-modify-write
  function automatic logic [7:0] rd_dir(input logic [7:0] a, input logic latch);
    logic [7:0] v;
    v = ram[a];
    if (a[7]) begin
      if (a == `CJA_SFR_ACC) v = acc_reg;
      else if (a == `CJA_SFR_PSW) v = psw_reg;
      else if (a == `CJA_SFR_SP) v = sp_reg;
      else if (a == `CJA_SFR_PORT) v = latch ? latch_reg : pin_sync_reg;
      else v = `CJA_RST_BYTE;
    end
    return v;
  endfunction

  // instruction fields and class decode
  wire [7:0] op = instr.op;
  wire [7:0] arg1 = instr.arg1;
  wire [2:0] op_hi = op[7:5];
  wire src_form = op[3:0] >= `CJA_SRC_IMM;
  wire is_add = op[7:4] == `CJA_OP_ADD_HI && src_form;
  wire is_addcy = op[7:4] == `CJA_OP_ADDCY_HI && src_form;
  wire is_and_a = op[7:4] == `CJA_OP_AND_HI && src_form;
  wire is_and_da = op == `CJA_OP_AND_DA;
  wire is_and_di = op == `CJA_OP_AND_DI;
  wire is_and_cn = op == `CJA_OP_AND_CN;
  wire is_jump = op[4:0] == `CJA_OP_JUMP_LO;
  wire is_call = op[4:0] == `CJA_OP_CALL_LO && !is_and_da; // byte form wins the clash
  wire is_arith = is_add || is_addcy;
  wire dir_wr = is_and_da || is_and_di;
  wire legal = is_arith || is_and_a || dir_wr || is_and_cn || is_jump || is_call;
  wire go = instr_valid && legal;

  // direct-space bytes, filled in by the read process further down
  logic [7:0] dir_src, dir_old, bit_byte;

  // source operand: register, direct, indirect or immediate
  wire [7:0] reg_addr = {3'b000, psw_reg[4:3], op[2:0]};
  wire [7:0] ptr_addr = {3'b000, psw_reg[4:3], 2'b00, op[0]};
  wire [7:0] src_byte = (op[3:0] == `CJA_SRC_IMM) ? arg1 :
                        (op[3:0] == `CJA_SRC_DIR) ? dir_src :
                        op[3] ? ram[reg_addr] : ram[ram[ptr_addr]];

  // adder shared by add and add-with-carry
  wire add_cin = is_addcy && psw_reg[`CJA_PSW_CY];
  logic [7:0] add_sum;
  logic add_cy, add_aux, add_ovf;
  cja_adder u_adder (
    .a(acc_reg),
    .b(src_byte),
    .cin(add_cin),
    .sum(add_sum),
    .cy(add_cy),
    .aux(add_aux),
    .ovf(add_ovf)
  );

  // direct destination: old value from the latch, never the pins
  wire [7:0] dir_mask = is_and_da ? acc_reg : instr.arg2;
  wire [7:0] dir_val = dir_old & dir_mask;
  wire dir_go = go && dir_wr;

  // addressed bit for the carry-AND-complement form
  wire [7:0] bit_byte_addr = arg1[7] ? {arg1[7:3], 3'b000} : (`CJA_BIT_RAM_BASE | {4'h0, arg1[6:3]});
  wire bit_val = bit_byte[arg1[2:0]];

  // rd_dir reads state beyond its arguments; a plain assign would miss a latch or ram change
  always_comb begin
    dir_src = rd_dir(arg1, 1'b0);
    dir_old = rd_dir(arg1, 1'b1);
    bit_byte = rd_dir(bit_byte_addr, 1'b0);
  end

  // program counter: advance by length, or load the 2K page address
  wire [15:0] pc_plus2 = pc_reg + 16'h0002;
  wire [7:0] pc2_lo = pc_plus2[7:0];
  wire [7:0] pc2_hi = pc_plus2[15:8];
  wire [4:0] pc2_top = pc_plus2[15:11];
  wire [15:0] page_tgt = {pc2_top, op_hi, arg1};
  // an unknown opcode always steps one byte, whatever its low nibble looks like
  wire [15:0] pc_len = is_and_di ? 16'h0003 :
                       (legal && src_form && op[3:1] == 3'b010) || is_and_da || is_and_cn ? 16'h0002 : 16'h0001;
  assign pc_next = !instr_valid ? pc_reg :
                   go && (is_jump || is_call) ? page_tgt : pc_reg + pc_len;

  // stack: two pre-incremented pushes, low byte first
  wire [7:0] sp_plus1 = sp_reg + 8'h01;
  wire [7:0] sp_plus2 = sp_reg + 8'h02;
  wire call_go = go && is_call;
  assign sp_next = call_go ? sp_plus2 : (dir_go && arg1 == `CJA_SFR_SP) ? dir_val : sp_reg;

  // accumulator: arithmetic, AND with source, or AND as direct destination
  assign acc_next = go && is_arith ? add_sum :
                    go && is_and_a ? (acc_reg & src_byte) :
                    (dir_go && arg1 == `CJA_SFR_ACC) ? dir_val : acc_reg;

  // flags: arithmetic, the carry-AND form and a direct AND into PSW touch them
  wire [7:0] psw_arith = {add_cy, add_aux, psw_reg[5:3], add_ovf, psw_reg[1:0]};
  wire [7:0] psw_andn = {psw_reg[7] & ~bit_val, psw_reg[6:0]};
  assign psw_next = go && is_arith ? psw_arith :
                    go && is_and_cn ? psw_andn :
                    (dir_go && arg1 == `CJA_SFR_PSW) ? dir_val : psw_reg;

  assign latch_next = (dir_go && arg1 == `CJA_SFR_PORT) ? dir_val : latch_reg;

  // pins cross in through two flops; only the second is read
  always_ff @(posedge clk_sys) begin
    pin_meta_reg <= port_pin;
    pin_sync_reg <= pin_meta_reg;
  end

  // architectural registers, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pc_reg <= `CJA_RST_PC;
      sp_reg <= `CJA_RST_SP;
      acc_reg <= `CJA_RST_BYTE;
      psw_reg <= `CJA_RST_BYTE;
      latch_reg <= `CJA_RST_LATCH;
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      pc_reg <= pc_next;
      sp_reg <= sp_next;
      acc_reg <= acc_next;
      psw_reg <= psw_next;
      latch_reg <= latch_next;
      done_reg <= instr_valid;
      illegal_reg <= instr_valid && !legal;
    end
  end

  // internal ram: push writes, and the direct AND destination below 80h
  always_ff @(posedge clk_sys) begin
    if (rstn && call_go) begin
      ram[sp_plus1] <= pc2_lo;
      ram[sp_plus2] <= pc2_hi;
    end
    if (rstn && dir_go && !arg1[7]) begin
      ram[arg1] <= dir_val;
    end
  end

  assign core_state = '{program_counter: pc_reg, stack_pointer: sp_reg, acc: acc_reg, psw: psw_reg};
  assign port_latch = latch_reg;
  assign instr_done = done_reg;
  assign instr_illegal = illegal_reg;

  // reference arithmetic for the checks, written independently of the adder
  wire [8:0] chk_sum = {1'b0, acc_reg} + {1'b0, src_byte} + {8'h00, add_cin};
  wire chk_c6 = chk_sum[7] ^ acc_reg[7] ^ src_byte[7];
  wire chk_aux = (acc_reg[3:0] + src_byte[3:0] + {3'b000, add_cin}) > 5'h0F;
  wire cy_now = psw_reg[`CJA_PSW_CY];
  wire aux_now = psw_reg[`CJA_PSW_AUX];
  wire ovf_now = psw_reg[`CJA_PSW_OVF];
  wire [7:0] chk_res = chk_sum[7:0];
  wire chk_cy = chk_sum[8];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_call;
    instr_valid && is_call;
  endsequence
  sequence s_pushed;
    sp_reg == 8'($past(sp_reg) + 8'h02) ##0 ram[sp_reg] == $past(pc2_hi) ##0 ram[8'(sp_reg - 8'h01)] == $past(pc2_lo);
  endsequence

  a_call_push: assert property (s_call |=> s_pushed ##0 psw_reg == $past(psw_reg))
    else $error("call push wrong");
  a_call_target: assert property (s_call |=> pc_reg == {$past(pc2_top), $past(op_hi), $past(arg1)})
    else $error("call target wrong");
  a_jump_target: assert property (instr_valid && is_jump |=>
    pc_reg == {$past(pc2_top), $past(op_hi), $past(arg1)} && sp_reg == $past(sp_reg))
    else $error("jump target wrong");
  a_add_carries: assert property (instr_valid && is_arith |=>
    cy_now == $past(chk_cy) && aux_now == $past(chk_aux))
    else $error("carry or aux carry wrong");
  a_add_overflow: assert property (instr_valid && is_arith |=>
    ovf_now == ($past(chk_c6) ^ $past(chk_cy)))
    else $error("overflow wrong");
  a_add_result: assert property (instr_valid && is_add |=> acc_reg == $past(chk_res))
    else $error("add result wrong");
  a_carry_added: assert property (instr_valid && is_addcy && cy_now |=>
    acc_reg == 8'($past(acc_reg) + $past(src_byte) + 8'h01))
    else $error("carry not added");
  a_addcy_len: assert property (instr_valid && is_addcy |=>
    pc_reg == 16'($past(pc_reg) + (($past(op) & 8'h0E) == 8'h04 ? 16'h0002 : 16'h0001)))
    else $error("add-with-carry length wrong");
  a_and_flags: assert property (instr_valid && (is_and_a || (dir_wr && arg1 != `CJA_SFR_PSW)) |=>
    psw_reg == $past(psw_reg))
    else $error("logical-AND touched flags");
  a_and_acc: assert property (instr_valid && is_and_a |=> acc_reg == ($past(acc_reg) & $past(src_byte)))
    else $error("logical-AND result wrong");
  a_and_latch: assert property (instr_valid && dir_wr && arg1 == `CJA_SFR_PORT |=>
    port_latch == ($past(port_latch) & $past(dir_mask)))
    else $error("port AND not from latch");
  a_carry_andn: assert property (instr_valid && is_and_cn |=> cy_now == ($past(cy_now) & ~$past(bit_val)))
    else $error("carry AND complement wrong");

endmodule

`default_nettype wire

// ===== cja_map.svh
/*
  Constants for the call, jump, add and logical-AND execution block:
  opcode encodings, special-register addresses, flag positions, reset values.
  Assumes it is included by bare name inside the package and the design files.
*/
`ifndef CJA_MAP_SVH
`define CJA_MAP_SVH

// opcode fields (low five bits for the 11-bit address forms)
`define CJA_OP_JUMP_LO 5'h01
`define CJA_OP_CALL_LO 5'h12
`define CJA_OP_ADD_HI 4'h2
`define CJA_OP_ADDCY_HI 4'h3
`define CJA_OP_AND_HI 4'h5
`define CJA_OP_AND_DA 8'h52
`define CJA_OP_AND_DI 8'h53
`define CJA_OP_AND_CN 8'hB0

// low nibble of the source modes
`define CJA_SRC_IMM 4'h4
`define CJA_SRC_DIR 4'h5

// special registers in the direct space
`define CJA_SFR_SP 8'h81
`define CJA_SFR_PORT 8'h90
`define CJA_SFR_PSW 8'hD0
`define CJA_SFR_ACC 8'hE0
`define CJA_BIT_RAM_BASE 8'h20

// flag positions inside the status word
`define CJA_PSW_CY 7
`define CJA_PSW_AUX 6
`define CJA_PSW_OVF 2

// reset values
`define CJA_RST_PC 16'h0000
`define CJA_RST_SP 8'h07
`define CJA_RST_BYTE 8'h00
`define CJA_RST_LATCH 8'hFF

`endif

// ===== cja_pkg.sv
/*
  Types shared by the execution block: the instruction word and the
  architectural state seen by the rest of the core.
  Assumes cja_map.svh is on the include path.
*/
`include "cja_map.svh"

package cja_pkg;

  // one instruction as fetched: opcode plus up to two trailing bytes
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] arg1;
    logic [7:0] arg2;
  } cja_instr_t;

  // architectural state driven out of the block
  typedef struct packed {
    logic [15:0] program_counter;
    logic [7:0] stack_pointer;
    logic [7:0] acc;
    logic [7:0] psw;
  } cja_core_t;

endpackage

// ===== cja_adder.sv
/*
  Eight-bit adder with carry in, producing the carry, aux-carry and overflow
  flags. Purely combinational; assumes its operands are stable within a cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module cja_adder (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  output logic [7:0] sum,
  output logic cy,
  output logic aux,
  output logic ovf
);
  import cja_pkg::*;

  logic [4:0] nib_sum;
  logic [7:0] low7_sum;
  logic [8:0] full_sum;

  // three partial sums give the carries out of bits 3, 6 and 7
  assign nib_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign low7_sum = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
  assign full_sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign sum = full_sum[7:0];
  assign cy = full_sum[8];
  assign aux = nib_sum[4];
  assign ovf = low7_sum[7] ^ full_sum[8]; // exactly one of the two carries

endmodule

`default_nettype wire

// ===== cja_exec_tb.sv
/*
  Self-checking bench for cja_exec: a table of back-to-back instructions
  with the architectural state each must leave, then idle and reset cases.
  Assumes cja_pkg (and cja_map.svh) are compiled ahead of this file.
*/
`timescale 1ns/1ps
`default_nettype none

module cja_exec_tb;
  import cja_pkg::*;

  // one table row: instruction, expected {pc,sp,acc,psw}, latch, illegal
  typedef struct packed {
    logic [23:0] ins;
    logic [39:0] st;
    logic [7:0] lat;
    logic ill;
  } cja_row_t;

  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic instr_valid = 1'b0;
  cja_instr_t instr = 24'h00_0000;
  logic [7:0] port_pin = 8'h0f;
  cja_core_t core_state;
  logic [7:0] port_latch;
  logic instr_done;
  logic instr_illegal;
  int err_total = 0;
  int n_tests = 0;
  cja_row_t rows [27];

  // 200 MHz core clock
  always #2.5 clk_sys = ~clk_sys;

  cja_exec dut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .instr_valid(instr_valid),
    .instr(instr),
    .port_pin(port_pin),
    .core_state(core_state),
    .port_latch(port_latch),
    .instr_done(instr_done),
    .instr_illegal(instr_illegal)
  );

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // whole visible state at once, so a stray write anywhere shows
  task automatic chk_all(input logic [39:0] st, input logic [7:0] lat, input logic dn, input logic il);
    check("core_state", core_state, st);
    check("port_latch", {32'h0000_0000, port_latch}, {32'h0000_0000, lat});
    check("instr_done", {39'h00_0000_0000, instr_done}, {39'h00_0000_0000, dn});
    check("instr_illegal", {39'h00_0000_0000, instr_illegal}, {39'h00_0000_0000, il});
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // the whole run is under 50 cycles; 200 cycles means a hang
  initial begin
    #1000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    // pins differ from the latch so a read-modify from pins is caught
    rows = '{
      '{24'h24_c300, 40'h00_0207_c300, 8'hff, 1'b0},
      '{24'h34_aa00, 40'h00_0407_6d84, 8'hff, 1'b0},
      '{24'hb0_e100, 40'h00_0607_6d84, 8'hff, 1'b0},
      '{24'h34_0000, 40'h00_0807_6e00, 8'hff, 1'b0},
      '{24'h24_9200, 40'h00_0a07_00c0, 8'hff, 1'b0},
      '{24'hb0_d600, 40'h00_0c07_0040, 8'hff, 1'b0},
      '{24'h24_4000, 40'h00_0e07_4000, 8'hff, 1'b0},
      '{24'h24_4000, 40'h00_1007_8004, 8'hff, 1'b0},
      '{24'h54_f000, 40'h00_1207_8004, 8'hff, 1'b0},
      '{24'h53_9073, 40'h00_1507_8004, 8'h73, 1'b0},
      '{24'h53_905a, 40'h00_1807_8004, 8'h52, 1'b0},
      '{24'h53_8106, 40'h00_1b06_8004, 8'h52, 1'b0},
      '{24'h72_4500, 40'h03_4508_8004, 8'h52, 1'b0},
      '{24'hf2_1000, 40'h07_100a_8004, 8'h52, 1'b0},
      '{24'h2f_0000, 40'h07_110a_9d00, 8'h52, 1'b0},
      '{24'h35_0a00, 40'h07_130a_a040, 8'h52, 1'b0},
      '{24'h25_0900, 40'h07_150a_e700, 8'h52, 1'b0},
      '{24'h21_2300, 40'h01_230a_e700, 8'h52, 1'b0},
      '{24'h5f_0000, 40'h01_240a_0500, 8'h52, 1'b0},
      '{24'h52_0a00, 40'h01_260a_0500, 8'h52, 1'b0},
      '{24'h35_0a00, 40'h01_280a_0600, 8'h52, 1'b0},
      '{24'h55_0900, 40'h01_2a0a_0600, 8'h52, 1'b0},
      '{24'h3f_0000, 40'h01_2b0a_2340, 8'h52, 1'b0},
      '{24'ha5_0000, 40'h01_2c0a_2340, 8'h52, 1'b1},  // illegal opcode
      '{24'he1_fe00, 40'h07_fe0a_2340, 8'h52, 1'b0},
      '{24'h01_0500, 40'h08_050a_2340, 8'h52, 1'b0},
      '{24'h53_d000, 40'h08_080a_2300, 8'h52, 1'b0}
    };
    repeat (6) @(negedge clk_sys);
    chk_all(40'h00_0007_0000, 8'hff, 1'b0, 1'b0);  // reset values
    rstn = 1'b1;
    // back to back, one instruction every cycle
    foreach (rows[i]) begin
      instr_valid = 1'b1;
      instr = rows[i].ins;
      @(negedge clk_sys);
      chk_all(rows[i].st, rows[i].lat, 1'b1, rows[i].ill);
    end
    // no request: nothing may move
    instr_valid = 1'b0;
    @(negedge clk_sys);
    chk_all(rows[26].st, rows[26].lat, 1'b0, 1'b0);
    // reset in mid-run wins over a pending instruction
    rstn = 1'b0;
    instr_valid = 1'b1;
    instr = 24'h24_0100;
    @(negedge clk_sys);
    chk_all(40'h00_0007_0000, 8'hff, 1'b0, 1'b0);  // reset values
    rstn = 1'b1;
    @(negedge clk_sys);
    chk_all(40'h00_0207_0100, 8'hff, 1'b1, 1'b0);
    // stack pointer cleared so the call pushes into pointer register 1
    instr = 24'h53_8100;
    @(negedge clk_sys);
    chk_all(40'h00_0500_0100, 8'hff, 1'b1, 1'b0);
    instr = 24'h12_2000;
    @(negedge clk_sys);
    chk_all(40'h00_2002_0100, 8'hff, 1'b1, 1'b0);
    // pointer register 1 holds 07, whose byte is 1d; a plain register read would give 08
    instr = 24'h27_0000;
    @(negedge clk_sys);
    chk_all(40'h00_2102_1e00, 8'hff, 1'b1, 1'b0);
    // a source read of the port sees the synchronised pins (0f), not the latch (ff)
    instr = 24'h25_9000;
    @(negedge clk_sys);
    chk_all(40'h00_2302_2d40, 8'hff, 1'b1, 1'b0);
    instr_valid = 1'b0;
    tally_and_finish();
  end
endmodule

`default_nettype wire
